// ---- design/cfl_regs.vh ----
// constants for the cell-based frame link transmit core
`ifndef CFL_REGS_VH
`define CFL_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define CFL_OFF_CTRL 4'h0
`define CFL_OFF_STATUS 4'h4
`define CFL_OFF_MASK 4'h8
`define CFL_OFF_STATE 4'hc

// ****************************************
// field positions and reset values
// ****************************************
`define CFL_CTRL_EN 0
`define CFL_CTRL_RST 32'h0000_0001
`define CFL_ST_FRAME 0
`define CFL_ST_OPC 1
`define CFL_ST_PAUSE 2
`define CFL_ST_W 3
`define CFL_MASK_RST 3'h0

// ****************************************
// link control codes, upper byte of a control word
// ****************************************
`define CFL_K_IDLE 8'hbc
`define CFL_K_SOC 8'h5c
`define CFL_K_OPC 8'h7c

// ****************************************
// cell check polynomial and seed
// ****************************************
`define CFL_CRC_POLY 16'h1021
`define CFL_CRC_SEED 16'hffff

// ****************************************
// timing and fixed sizes
// ****************************************
`define CFL_CLK_NS 4
`define CFL_CHANNELS 4
`define CFL_SEQ_W 5

`endif

// ---- design/cfl_rr_arbiter.v ----
// round robin picker over the four channels
`timescale 1ns/10ps
`default_nettype none

module cfl_rr_arbiter (
  input wire [3:0] req_in,
  input wire [1:0] last_in,
  output reg grant_vld_out,
  output reg [1:0] grant_ch_out
);

  // ****************************************
  // search starts one past the last grant
  // ****************************************
  reg [1:0] idx; // candidate channel
  integer k; // search step

  // first requester after the last winner wins
  always @* begin
    idx = 2'h0;
    grant_vld_out = 1'b0;
    grant_ch_out = 2'h0;
    for (k = 4; k >= 1; k = k - 1) begin
      idx = last_in + k[1:0];
      if (req_in[idx]) begin
        grant_vld_out = 1'b1;
        grant_ch_out = idx;
      end
    end
  end

endmodule

`default_nettype wire

// ---- design/cfl_cell_crc.v ----
// one-word step of the cell check sum
`timescale 1ns/10ps
`default_nettype none
`include "cfl_regs.vh"

module cfl_cell_crc #(
  parameter W = 16
) (
  input wire [15:0] crc_in,
  input wire [W-1:0] data_in,
  output reg [15:0] crc_out
);

  // ****************************************
  // bit-serial fold, msb first
  // ****************************************
  integer b; // bit index
  reg fb; // feedback bit

  // shift every data bit through the polynomial
  always @* begin
    crc_out = crc_in;
    fb = 1'b0;
    for (b = W - 1; b >= 0; b = b - 1) begin
      fb = crc_out[15] ^ data_in[b];
      crc_out = {crc_out[14:0], 1'b0};
      if (fb) begin
        crc_out = crc_out ^ `CFL_CRC_POLY;
      end
    end
  end

endmodule

`default_nettype wire

// ---- design/cfl_link_core.v ----
// transmit core: channels into checked cells on the serial link
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "cfl_regs.vh"

module cfl_link_core #(
  parameter lane_count_param = 1,
  parameter channel_interleave_param = 1,
  parameter payload_counter_msb = 7
) (
  input wire core_clk_in,
  input wire sys_rst_in,
  input wire transmit_side_clear_in,
  input wire frame_state_clear_in,
  input wire [3:0] channel_word_valid_in,
  input wire [3:0] channel_sof_in,
  input wire [3:0] channel_eof_in,
  input wire [3:0] channel_eofe_in,
  input wire [4*16*lane_count_param-1:0] channel_data_in,
  input wire [3:0] channel_threshold_high_in,
  input wire [3:0] channel_threshold_full_in,
  input wire [7:0] sideband_user_byte_in,
  input wire sideband_code_strobe_in,
  input wire [7:0] sideband_code_value_in,
  output reg [3:0] channel_word_accept_out,
  output reg [16*lane_count_param-1:0] link_data_out,
  output reg link_ctrl_out,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg irq_out
);

  // ****************************************
  // sizes and states
  // ****************************************
  localparam W = 16 * lane_count_param;
  localparam PW = payload_counter_msb + 1; // payload counter width
  localparam [PW-1:0] PMAX = {PW{1'b1}}; // words per cell, 255 at msb 7
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_HDR0 = 3'h1;
  localparam [2:0] ST_HDR1 = 3'h2;
  localparam [2:0] ST_PAY = 3'h3;
  localparam [2:0] ST_TRL = 3'h4;
  localparam [2:0] ST_CRC = 3'h5;

  // ****************************************
  // state
  // ****************************************
  reg [2:0] state; // cell sequencer
  reg [2:0] next_state;
  reg [1:0] cur_ch; // channel owning the cell
  reg [1:0] next_ch;
  reg [1:0] last_ch; // last round robin winner
  reg [PW-1:0] pay_cnt; // words in this cell
  reg [PW-1:0] next_pay_cnt;
  reg [3:0] in_frame; // frame open per channel
  reg [3:0] next_in_frame;
  reg [`CFL_SEQ_W-1:0] seq [0:3]; // cell sequence per channel
  reg [15:0] crc; // running cell check
  reg [15:0] next_crc;
  reg op_pend; // opcode waiting for a slot
  reg [7:0] op_code; // latched opcode
  reg cell_eof; // trailer marks
  reg cell_eofe;
  reg next_eof;
  reg next_eofe;
  reg [W-1:0] next_data;
  reg next_ctrl;
  reg [3:0] next_accept;
  reg [`CFL_ST_W-1:0] ev; // events this cycle
  reg tx_en; // software enable for new cells
  reg [`CFL_ST_W-1:0] irq_st; // sticky events
  reg [`CFL_ST_W-1:0] irq_mask;
  reg [`CFL_ST_W-1:0] next_st;
  reg [`CFL_ST_W-1:0] st_clr;
  wire clr = transmit_side_clear_in;
  wire [W-1:0] sel_data = channel_data_in[cur_ch*W +: W];
  wire sel_valid = channel_word_valid_in[cur_ch];
  wire take = channel_word_accept_out[cur_ch] & sel_valid;
  wire [15:0] crc_step;
  wire gnt_vld;
  wire [1:0] gnt_ch;
  reg [3:0] arb_req;
  reg [2:0] lock_k; // lock search index
  integer i;
  integer j; // sequence reset index, kept apart from the accept loop

  // ****************************************
  // arbitration and check sum
  // ****************************************
  // non-interleave: an open frame keeps the link
  always @* begin
    arb_req = channel_word_valid_in;
    if (channel_interleave_param == 0) begin
      for (lock_k = 3'h0; lock_k < 3'h4; lock_k = lock_k + 3'h1) begin
        if (in_frame[lock_k[1:0]]) begin
          arb_req = channel_word_valid_in & (4'h1 << lock_k[1:0]);
        end
      end
    end
  end

  cfl_rr_arbiter u_arb (
    .req_in(arb_req),
    .last_in(last_ch),
    .grant_vld_out(gnt_vld),
    .grant_ch_out(gnt_ch)
  );

  cfl_cell_crc #(.W(W)) u_crc (
    .crc_in(crc),
    .data_in(next_data),
    .crc_out(crc_step)
  );

  // ****************************************
  // sequencer next state and link word
  // ****************************************
  always @* begin
    next_state = state;
    next_ch = cur_ch;
    next_pay_cnt = pay_cnt;
    next_in_frame = in_frame;
    next_crc = crc;
    next_eof = cell_eof;
    next_eofe = cell_eofe;
    next_data = {W{1'b0}};
    next_ctrl = 1'b1;
    ev = {`CFL_ST_W{1'b0}};
    if (op_pend) begin
      // opcode takes this slot, cells hold still
      next_data[15:0] = {`CFL_K_OPC, op_code};
      ev[`CFL_ST_OPC] = 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          next_data[15:0] = {`CFL_K_IDLE, 8'h00};
          if (gnt_vld && tx_en) begin
            next_ch = gnt_ch;
            next_state = ST_HDR0;
          end
        end
        ST_HDR0: begin
          // start of cell carries the sideband byte
          next_data[15:0] = {`CFL_K_SOC, sideband_user_byte_in};
          next_crc = `CFL_CRC_SEED;
          next_state = ST_HDR1;
        end
        ST_HDR1: begin
          // thresholds, channel, frame start, sequence
          next_ctrl = 1'b0;
          next_data[15:0] = {channel_threshold_full_in[1], channel_threshold_high_in[1],
            channel_threshold_full_in[0], channel_threshold_high_in[0],
            channel_threshold_full_in[3], channel_threshold_high_in[3],
            channel_threshold_full_in[2], channel_threshold_high_in[2],
            cur_ch, channel_sof_in[cur_ch],
            channel_sof_in[cur_ch] ? {`CFL_SEQ_W{1'b0}} : seq[cur_ch]};
          next_crc = crc_step;
          next_pay_cnt = {PW{1'b0}};
          next_eof = 1'b0;
          next_eofe = 1'b0;
          next_state = ST_PAY;
        end
        ST_PAY: begin
          next_ctrl = 1'b0;
          if (take) begin
            next_data = sel_data;
            next_crc = crc_step;
            next_pay_cnt = pay_cnt + {{(PW-1){1'b0}}, 1'b1};
            next_in_frame[cur_ch] = ~channel_eof_in[cur_ch];
            if (channel_eof_in[cur_ch]) begin
              next_eof = 1'b1;
              next_eofe = channel_eofe_in[cur_ch];
              next_state = ST_TRL;
            end else if (next_pay_cnt == PMAX) begin
              next_state = ST_TRL;
            end
          end else if (channel_word_accept_out[cur_ch]) begin
            // user paused: close cell, frame resumes later
            next_data[15:0] = {`CFL_K_IDLE, 8'h00};
            next_ctrl = 1'b1;
            next_state = ST_TRL;
            ev[`CFL_ST_PAUSE] = 1'b1;
          end else begin
            next_data[15:0] = {`CFL_K_IDLE, 8'h00};
            next_ctrl = 1'b1;
          end
        end
        ST_TRL: begin
          // end marks close the protected part
          next_ctrl = 1'b0;
          next_data[15:0] = {cell_eof, cell_eofe, 6'h00, 8'h00};
          next_crc = crc_step;
          next_state = ST_CRC;
        end
        ST_CRC: begin
          next_ctrl = 1'b0;
          next_data[15:0] = crc;
          next_state = ST_IDLE;
          ev[`CFL_ST_FRAME] = cell_eof;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
    if (frame_state_clear_in) begin
      // frame state drops, idle words keep the link up
      next_state = ST_IDLE;
      next_in_frame = 4'h0;
    end
  end

  // accept only in payload, never under a pending opcode
  always @* begin
    next_accept = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      if (next_state == ST_PAY && next_ch == i[1:0] && !clr &&
          !sideband_code_strobe_in && !(op_pend && state != ST_PAY)) begin
        next_accept[i] = 1'b1;
      end
    end
  end

  // ****************************************
  // sequencer registers
  // ****************************************
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      cur_ch <= 2'h0;
      last_ch <= 2'h3;
      pay_cnt <= {PW{1'b0}};
      in_frame <= 4'h0;
      crc <= `CFL_CRC_SEED;
      cell_eof <= 1'b0;
      cell_eofe <= 1'b0;
      op_pend <= 1'b0;
      op_code <= 8'h00;
      channel_word_accept_out <= 4'h0;
      link_data_out <= {W{1'b0}};
      link_ctrl_out <= 1'b1;
    end else if (clr) begin
      state <= ST_IDLE;
      cur_ch <= 2'h0;
      last_ch <= 2'h3;
      pay_cnt <= {PW{1'b0}};
      in_frame <= 4'h0;
      crc <= `CFL_CRC_SEED;
      cell_eof <= 1'b0;
      cell_eofe <= 1'b0;
      op_pend <= 1'b0;
      channel_word_accept_out <= 4'h0;
      link_data_out <= {W{1'b0}};
      link_ctrl_out <= 1'b1;
    end else begin
      state <= next_state;
      cur_ch <= next_ch;
      if (state == ST_IDLE && next_state == ST_HDR0) begin
        last_ch <= next_ch;
      end
      pay_cnt <= next_pay_cnt;
      in_frame <= next_in_frame;
      crc <= next_crc;
      cell_eof <= next_eof;
      cell_eofe <= next_eofe;
      // strobe latched; one cycle of stall sends it
      if (sideband_code_strobe_in) begin
        op_pend <= 1'b1;
        op_code <= sideband_code_value_in;
      end else begin
        op_pend <= 1'b0;
      end
      channel_word_accept_out <= next_accept;
      link_data_out <= next_data;
      link_ctrl_out <= next_ctrl;
    end
  end

  // per-channel sequence: restart on frame start, step per cell
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (j = 0; j < 4; j = j + 1) begin
        seq[j] <= {`CFL_SEQ_W{1'b0}};
      end
    end else if (clr || frame_state_clear_in) begin
      for (j = 0; j < 4; j = j + 1) begin
        seq[j] <= {`CFL_SEQ_W{1'b0}};
      end
    end else if (state == ST_HDR1 && !op_pend) begin
      seq[cur_ch] <= (channel_sof_in[cur_ch] ? {`CFL_SEQ_W{1'b0}} : seq[cur_ch])
        + {{(`CFL_SEQ_W-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // register bus slave
  // ****************************************
  wire req = (avs_read | avs_write) & avs_waitrequest;
  wire wr_go = avs_write & ~avs_waitrequest;

  // write-one clears only on the status offset
  always @* begin
    st_clr = {`CFL_ST_W{1'b0}};
    if (wr_go && avs_address == `CFL_OFF_STATUS) begin
      st_clr = avs_writedata[`CFL_ST_W-1:0];
    end
    next_st = (irq_st & ~st_clr) | ev; // set wins
  end

  // one wait cycle, then data and write take effect
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      tx_en <= 1'b1;
      irq_mask <= `CFL_MASK_RST;
      irq_st <= {`CFL_ST_W{1'b0}};
      irq_out <= 1'b0;
    end else begin
      avs_waitrequest <= ~req;
      irq_st <= next_st;
      irq_out <= |(next_st & irq_mask);
      if (req && avs_read) begin
        case (avs_address)
          `CFL_OFF_CTRL: avs_readdata <= {31'h0, tx_en};
          `CFL_OFF_STATUS: avs_readdata <= {29'h0, irq_st};
          `CFL_OFF_MASK: avs_readdata <= {29'h0, irq_mask};
          `CFL_OFF_STATE: avs_readdata <= {20'h0, in_frame, 1'b0, op_pend, cur_ch,
            1'b0, state};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
      if (wr_go && avs_address == `CFL_OFF_CTRL) begin
        tx_en <= avs_writedata[`CFL_CTRL_EN];
      end
      if (wr_go && avs_address == `CFL_OFF_MASK) begin
        irq_mask <= avs_writedata[`CFL_ST_W-1:0];
      end
    end
  end

endmodule

`default_nettype wire

// ---- dv/cfl_link_checker.sv ----
// port assertions for the link transmit core
`timescale 1ns/10ps
`default_nettype none
`include "cfl_regs.vh"
module cfl_link_checker #(
  parameter lane_count_param = 1,
  parameter payload_counter_msb = 7
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic transmit_side_clear_in,
  input wire logic frame_state_clear_in,
  input wire logic [3:0] channel_word_valid_in,
  input wire logic [4*16*lane_count_param-1:0] channel_data_in,
  input wire logic sideband_code_strobe_in,
  input wire logic [7:0] sideband_code_value_in,
  input wire logic [3:0] channel_word_accept_out,
  input wire logic [16*lane_count_param-1:0] link_data_out,
  input wire logic link_ctrl_out,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  localparam int PMAX = (1 << (payload_counter_msb + 1)) - 1; // words per cell
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [3:0] took; // channels moving a word
  logic [16*lane_count_param-1:0] sel_w; // word being moved
  logic soc, hdr_due; // header one seen, header two next
  logic [1:0] hdr_ch, cur_ch; // owner of the open cell
  logic [8:0] run; // words moved in this cell
  assign took = channel_word_accept_out & channel_word_valid_in;
  assign soc = link_ctrl_out && link_data_out[15:8] == `CFL_K_SOC;
  assign cur_ch = (hdr_due && !link_ctrl_out) ? link_data_out[7:6] : hdr_ch;
  // pick the word that moves this cycle
  always_comb begin
    sel_w = '0;
    for (int i = 0; i < 4; i++)
      if (took[i])
        sel_w = channel_data_in[i*16*lane_count_param +: 16*lane_count_param];
  end
  // track cell owner and cell length
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hdr_due <= 1'b0;
      hdr_ch <= 2'h0;
      run <= 9'h000;
    end else begin
      hdr_due <= soc || (hdr_due && link_ctrl_out);
      hdr_ch <= cur_ch;
      run <= (channel_word_accept_out == 4'h0) ? 9'h000 : run + {8'h00, |took};
    end
  end
  sequence opc_s;
    link_ctrl_out && link_data_out[15:0] == {`CFL_K_OPC, $past(sideband_code_value_in, 2)};
  endsequence
  sequence pause_s;
    |(channel_word_accept_out & ~channel_word_valid_in);
  endsequence
  one_owner_a:
    assert property ($onehot0(channel_word_accept_out)) else $error("two channels accept");
  word_pass_a:
    assert property (|took |=> !link_ctrl_out && link_data_out == $past(sel_w))
      else $error("taken word not on link");
  cell_owner_a:
    assert property (|channel_word_accept_out |-> channel_word_accept_out[cur_ch])
      else $error("accept not on cell owner");
  op_send_a:
    assert property (sideband_code_strobe_in |-> ##2 opc_s) else $error("opcode word late");
  pause_close_a:
    assert property (pause_s |=> (channel_word_accept_out
      & $past(channel_word_accept_out & ~channel_word_valid_in)) == 4'h0)
      else $error("cell not closed on pause");
  cell_size_a:
    assert property (run <= PMAX) else $error("cell too long");
  tx_clear_a:
    assert property (transmit_side_clear_in |=> channel_word_accept_out == 4'h0
      && link_ctrl_out && link_data_out == '0) else $error("link clear ignored");
  frame_clear_a:
    assert property (frame_state_clear_in |=> channel_word_accept_out == 4'h0)
      else $error("frame clear ignored");
  bus_answer_a:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest
      ##1 avs_waitrequest) else $error("bus answer not one cycle");
endmodule
`default_nettype wire

// ---- dv/cfl_far_end.sv ----
// far end model: decodes cells, reports words and opcodes
`timescale 1ns/10ps
`default_nettype none
module cfl_far_end (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [15:0] link_data_in, // one lane, same count both ends
  input wire logic link_ctrl_in,
  output logic word_vld_out,
  output logic [1:0] word_ch_out,
  output logic [15:0] word_out,
  output logic op_vld_out,
  output logic [7:0] op_out,
  output logic [7:0] side_out,
  output logic [7:0] thr_out,
  output int crc_err_out,
  output int seq_err_out,
  output int eof_out
);
  logic [15:0] cell_q[$]; // words of the open cell
  logic [17:0] out_q[$]; // payload waiting to report
  logic [4:0] last_seq[4]; // last sequence per channel
  logic [1:0] ch;
  logic hdr_due = 1'b0, in_cell = 1'b0;
  logic end_due = 1'b0; // idle seen inside a cell, end unless data follows
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  // check the closed cell, queue its payload
  task automatic close_cell();
    logic [15:0] c;
    int n;
    c = 16'hffff;
    n = cell_q.size();
    for (int i = 0; i < n - 1; i++)
      c = crc_step(c, cell_q[i]);
    if (n < 3 || c !== cell_q[n-1]) crc_err_out++;
    else begin
      eof_out += cell_q[n-2][15];
      for (int i = 1; i < n - 2; i++)
        out_q.push_back({ch, cell_q[i]});
    end
    cell_q.delete();
    in_cell = 1'b0;
  endtask
  // decode one link word per cycle
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      word_vld_out <= 1'b0;
      op_vld_out <= 1'b0;
    end else begin
      word_vld_out <= out_q.size() > 0;
      op_vld_out <= 1'b0;
      if (out_q.size() > 0) {word_ch_out, word_out} <= out_q.pop_front();
      if (link_ctrl_in && link_data_in[15:8] == 8'h7c) begin
        op_vld_out <= 1'b1;
        op_out <= link_data_in[7:0];
      end else if (link_ctrl_in) begin
        // an idle inside a cell is a pause when a data word follows it
        if (in_cell && end_due) close_cell();
        end_due = in_cell;
        hdr_due = link_data_in[15:8] == 8'h5c;
        if (hdr_due) side_out <= link_data_in[7:0];
      end else if (hdr_due) begin
        hdr_due = 1'b0;
        in_cell = 1'b1;
        ch = link_data_in[7:6];
        thr_out <= link_data_in[15:8];
        if (link_data_in[4:0] !== (link_data_in[5] ? 5'h00 : last_seq[ch] + 5'h01))
          seq_err_out++;
        last_seq[ch] = link_data_in[4:0];
        cell_q.push_back(link_data_in);
      end else if (in_cell) begin
        end_due = 1'b0;
        cell_q.push_back(link_data_in);
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// bench: frames, opcodes, clears and registers through the core
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic tx_clr = 1'b0, fr_clr = 1'b0, op_stb = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [3:0] vld = 4'h0, sof = 4'h0, eof = 4'h0, th_h = 4'h0, th_f = 4'h0, addr = 4'h0;
  logic [63:0] dat = 64'h0;
  logic [7:0] side_b = 8'h00, op_val = 8'h00, o_val, p_side, p_thr;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [3:0] acc;
  logic [15:0] ldat, w_val;
  logic lctrl, wreq, irq, w_vld, o_vld;
  logic [1:0] w_ch;
  int crc_e, seq_e, eof_n, err_count = 0, n_compared = 0, cyc = 0;
  logic [15:0] exp_q[4][$]; // words per channel
  logic [7:0] op_q[$];
  logic [31:0] rd_q[$];
  always #2 core_clk_in = ~core_clk_in;
  cfl_link_core uut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .transmit_side_clear_in(tx_clr), .frame_state_clear_in(fr_clr),
    .channel_word_valid_in(vld), .channel_sof_in(sof), .channel_eof_in(eof),
    .channel_eofe_in(4'h0), .channel_data_in(dat), .channel_threshold_high_in(th_h),
    .channel_threshold_full_in(th_f), .sideband_user_byte_in(side_b),
    .sideband_code_strobe_in(op_stb), .sideband_code_value_in(op_val),
    .channel_word_accept_out(acc), .link_data_out(ldat), .link_ctrl_out(lctrl),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .irq_out(irq));
  cfl_far_end far (.clk_in(core_clk_in), .rst_in(sys_rst_in), .link_data_in(ldat),
    .link_ctrl_in(lctrl), .word_vld_out(w_vld), .word_ch_out(w_ch), .word_out(w_val),
    .op_vld_out(o_vld), .op_out(o_val), .side_out(p_side), .thr_out(p_thr),
    .crc_err_out(crc_e), .seq_err_out(seq_e), .eof_out(eof_n));
  task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one bus cycle, held until waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge core_clk_in); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // one frame on a channel, optional pause and open end
  task automatic send(input int c, input int len, input bit pz, input bit fin);
    logic [15:0] d;
    @(posedge core_clk_in);
    for (int i = 0; i < len; i++) begin
      d = $urandom;
      vld[c] <= 1'b1;
      sof[c] <= i == 0;
      eof[c] <= fin && i == len - 1;
      dat[c*16 +: 16] <= d;
      do @(posedge core_clk_in); while (acc[c] !== 1'b1);
      exp_q[c].push_back(d);
      if (pz && i == 2) begin
        vld[c] <= 1'b0;
        repeat (5) @(posedge core_clk_in);
      end
    end
    vld[c] <= 1'b0;
  endtask
  task automatic drain(input string nm);
    for (int i = 0; i < 400; i++) begin
      @(posedge core_clk_in);
      if (i > 20 && exp_q[0].size() + exp_q[1].size() + exp_q[2].size()
        + exp_q[3].size() + op_q.size() == 0) break;
    end
    cmp_reg("left words", 0, exp_q[0].size() + exp_q[1].size() + exp_q[2].size()
      + exp_q[3].size() + op_q.size());
    $display("test %s done", nm);
  endtask
  // watch results, oldest note first
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      give_verdict();
    end
    if (rd && wreq === 1'b0) cmp_reg("readdata", rd_q.pop_front(), rdata);
    if (w_vld === 1'b1) cmp_word("payload", exp_q[w_ch].pop_front(), w_val);
    if (o_vld === 1'b1) cmp_word("opcode", {8'h00, op_q.pop_front()}, {8'h00, o_val});
  end
  initial begin
    void'($urandom(94));
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    rd_chk(4'h0, 32'h1);
    rd_chk(4'h8, 32'h0);
    rd_chk(4'h2, 32'h0);
    $display("test registers done");
    side_b <= $urandom;
    th_h <= $urandom;
    th_f <= $urandom;
    fork
      send(0, 3, 0, 1);
      send(1, 1, 0, 1);
      send(2, 8, 1, 1);
      send(3, 5, 0, 1);
    join
    send(0, 300, 0, 1);
    drain("frames");
    cmp_word("sideband", side_b, p_side);
    cmp_word("thresholds", {th_f[1], th_h[1], th_f[0], th_h[0],
      th_f[3], th_h[3], th_f[2], th_h[2]}, p_thr);
    fork
      send(1, 20, 0, 1);
      for (int k = 0; k < 2; k++) begin
        repeat (3) @(posedge core_clk_in);
        op_stb <= 1'b1;
        op_val <= $urandom;
        @(posedge core_clk_in);
        op_q.push_back(op_val);
        op_stb <= 1'b0;
        repeat (520) @(posedge core_clk_in);
      end
    join
    drain("opcodes");
    rd_chk(4'h4, 32'h7);
    bus(1'b1, 4'h4, 32'h7);
    bus(1'b1, 4'h8, 32'h1);
    rd_chk(4'h4, 32'h0);
    cmp_reg("irq idle", 1'b0, irq);
    send(0, 1, 0, 1);
    drain("irq frame");
    cmp_reg("irq raised", 1'b1, irq);
    bus(1'b1, 4'h8, 32'h0);
    repeat (2) @(posedge core_clk_in);
    cmp_reg("irq masked", 1'b0, irq);
    bus(1'b1, 4'h8, 32'h1);
    bus(1'b1, 4'h4, 32'h1);
    repeat (2) @(posedge core_clk_in);
    cmp_reg("irq cleared", 1'b0, irq);
    send(3, 2, 0, 0);
    drain("open frame");
    rd_chk(4'hc, 32'h830);
    fr_clr <= 1'b1;
    @(posedge core_clk_in);
    fr_clr <= 1'b0;
    rd_chk(4'hc, 32'h30);
    send(3, 2, 0, 1);
    drain("frame clear");
    tx_clr <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    tx_clr <= 1'b0;
    side_b <= $urandom;
    send(2, 4, 0, 1);
    drain("link clear");
    cmp_word("sideband new", side_b, p_side);
    cmp_reg("crc errors", 0, crc_e);
    cmp_reg("seq errors", 0, seq_e);
    cmp_reg("eof cells", 9, eof_n);
    give_verdict();
  end
endmodule
bind cfl_link_core cfl_link_checker #(.lane_count_param(lane_count_param),
  .payload_counter_msb(payload_counter_msb)) chk (
  .core_clk_in(core_clk_in),
  .sys_rst_in(sys_rst_in),
  .transmit_side_clear_in(transmit_side_clear_in),
  .frame_state_clear_in(frame_state_clear_in),
  .channel_word_valid_in(channel_word_valid_in),
  .channel_data_in(channel_data_in),
  .sideband_code_strobe_in(sideband_code_strobe_in),
  .sideband_code_value_in(sideband_code_value_in),
  .channel_word_accept_out(channel_word_accept_out),
  .link_data_out(link_data_out),
  .link_ctrl_out(link_ctrl_out),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest));
`default_nettype wire
